// ===== rtl/dfr_aux.sv
`timescale 1ns/1ps
`include "dfr_map.svh"
module dfr_aux
  import dfr_pkg::*;
#(
  parameter int unsigned     CYC_PER_TENTH = `TENTH_NS / `CLK_NS,
  parameter longint unsigned CYC_PER_HOUR  = 64'(`TENTH_PER_H) * 64'(CYC_PER_TENTH)
)(
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire dfr_bus_t    bus,
  output logic [15:0]      rd_data_q,
  input  wire dfr_term_t   term,
  input  wire logic [15:0] set_freq,
  input  wire logic [7:0]  load_level,
  output logic [15:0]      out_freq_q,
  output logic             out_rev_q,
  output logic             run_q,
  output logic             jog_q,
  output logic [1:0]       start_mode_q,
  output logic             stop_mode_q,
  output logic             pon_reached_q,
  output logic             run_reached_q
);
  logic [15:0] cfg_q    [`NCFG];
  logic [15:0] hr_cnt_q [2];
  logic [39:0] hr_pre_q [2];
  logic [39:0] acc_q;
  logic [39:0] dz_cnt_q;
  dfr_state_t  state_q;
  dfr_status_t stat;

  logic        below;
  logic        stop_low;
  logic        stop_time;
  logic        jog_d;
  logic        run_d;
  logic        want_rev;
  logic        up;
  logic        down;
  logic        step;
  logic        free;
  logic        tgt_in;
  logic        nf_in;
  logic [1:0]  grp;
  logic [15:0] droop_set;
  logic [23:0] droop_prod;
  logic [15:0] drop;
  logic [15:0] tgt_raw;
  logic [15:0] tgt_dr;
  logic [15:0] tgt_sk;
  logic [15:0] t_lo;
  logic [15:0] t_hi;
  logic [15:0] tgt;
  logic [15:0] act_time;
  logic [39:0] lim;
  logic [39:0] dz_lim;
  logic [15:0] nf;
  logic [15:0] nf_lo;
  logic [15:0] nf_hi;
  logic [15:0] nf_j;

  function automatic logic [15:0] cfg_rst(input logic [4:0] a);
    logic [15:0] v;
    v = 16'h0000;
    if (a == `R_JOG_F)
      v = `JOG_F_RST;
    else if (a >= `R_JOG_UP && a <= `R_GRP_LAST)
      v = `TIME_RST;
    return v;
  endfunction

  // settings file; one register per entry, written whole
  for (genvar i = 0; i < `NCFG; i++)
  begin : g_cfg
    always_ff @(posedge clock)
    begin
      if (sys_rst)
        cfg_q[i] <= cfg_rst(5'(i));
      else if (bus.wr && bus.addr == 5'(i))
        cfg_q[i] <= bus.wdata;
    end
  end

  // a normal run blocks terminal jog unless priority is on
  assign jog_d     = term.jog && (jog_q || !term.run || cfg_q[`R_JOG_PRIO][0]);
  assign below     = set_freq < cfg_q[`R_LOW_LIM];
  assign stop_low  = below && cfg_q[`R_LOW_MODE] == `LOW_STOP && !jog_d;
  assign stop_time = run_reached_q && cfg_q[`R_RUN_ACT] == `ACT_STOP;
  assign run_d     = (term.run || jog_d) && !stop_low && !stop_time;
  assign want_rev  = term.rev && !cfg_q[`R_REV_INH][0];

  // requested frequency before droop and skipping
  always_comb
  begin
    tgt_raw = set_freq;
    if (jog_d)
      tgt_raw = cfg_q[`R_JOG_F];
    else if (below && cfg_q[`R_LOW_MODE] == `LOW_LIMIT)
      tgt_raw = cfg_q[`R_LOW_LIM];
    else if (below)
      tgt_raw = `ZERO_F;
  end

  // droop scales with load/256, so it never quite reaches the setting
  assign droop_set  = (cfg_q[`R_DROOP] > `DROOP_MAX) ? `DROOP_MAX : cfg_q[`R_DROOP];
  assign droop_prod = droop_set * load_level;
  assign drop       = droop_prod[23:`LOAD_SHIFT];
  assign tgt_dr     = (tgt_raw > drop) ? tgt_raw - drop : `ZERO_F;

  dfr_skip u_skip_tgt
  (
    .freq     (tgt_dr),
    .skip_one (cfg_q[`R_SKIP1]),
    .skip_two (cfg_q[`R_SKIP2]),
    .amp      (cfg_q[`R_SKIP_AMP]),
    .in_band  (tgt_in),
    .band_lo  (t_lo),
    .band_hi  (t_hi),
    .nearest  (tgt_sk)
  );

  // ramp toward zero while stopping or turning round
  assign tgt  = (run_d && want_rev == out_rev_q && state_q == ST_DRIVE) ? tgt_sk : `ZERO_F;
  assign up   = out_freq_q < tgt;
  assign down = out_freq_q > tgt;

  // ramp group: terminals first, then switchover points for motor 1
  always_comb
  begin
    grp = 2'h0;
    if (term.sel_act)
      grp = term.digital_input_terminal;
    else if (term.motor_one && up)
      grp = (out_freq_q < cfg_q[`R_UP_SW]) ? 2'h0 : 2'h1;
    else if (term.motor_one && down)
      grp = (out_freq_q > cfg_q[`R_DN_SW]) ? 2'h0 : 2'h1;
  end

  always_comb
  begin
    if (jog_q)
      act_time = down ? cfg_q[`R_JOG_DN] : cfg_q[`R_JOG_UP];
    else
      act_time = cfg_q[`R_UP1 + 5'({grp, down})];
  end

  // ramp time is the time for a full-scale swing; one step every lim/RAMP_FULL cycles, rounded up
  assign lim  = 40'(act_time) * 40'(CYC_PER_TENTH);
  assign step = (up || down) && (acc_q + `RAMP_FULL >= lim);
  assign free = !run_d && !jog_q && !jog_d && cfg_q[`R_STOP_MODE][0];

  always_comb
  begin
    nf = out_freq_q;
    if (free)
      nf = `ZERO_F;
    else if (step && up)
      nf = out_freq_q + 16'h0001;
    else if (step)
      nf = out_freq_q - 16'h0001;
  end

  dfr_skip u_skip_run
  (
    .freq     (nf),
    .skip_one (cfg_q[`R_SKIP1]),
    .skip_two (cfg_q[`R_SKIP2]),
    .amp      (cfg_q[`R_SKIP_AMP]),
    .in_band  (nf_in),
    .band_lo  (nf_lo),
    .band_hi  (nf_hi),
    .nearest  ()
  );

  // never dwell inside a band: cross it in one cycle
  assign nf_j = (cfg_q[`R_SKIP_RAMP][0] && nf_in) ? (down ? nf_lo : nf_hi) : nf;

  // remainder dropped on each step: a small rate error, no wide divider
  always_ff @(posedge clock)
  begin
    if (sys_rst || step || !(up || down))
      acc_q <= 40'h0;
    else
      acc_q <= acc_q + `RAMP_FULL;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      out_freq_q <= `ZERO_F;
    else
      out_freq_q <= nf_j;
  end

  // direction and dead zone; a stopped drive turns round at once
  assign dz_lim = 40'(cfg_q[`R_DEAD_T]) * 40'(CYC_PER_TENTH);

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      state_q   <= ST_DRIVE;
      dz_cnt_q  <= 40'h0;
      out_rev_q <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        ST_DRIVE:
        begin
          dz_cnt_q <= 40'h0;
          if (want_rev != out_rev_q && out_freq_q == `ZERO_F)
          begin
            if (run_d && dz_lim != 40'h0)
              state_q <= ST_DEAD;
            else
              out_rev_q <= want_rev;
          end
        end
        ST_DEAD:
        begin
          if (dz_cnt_q + 40'h1 >= dz_lim)
          begin
            state_q   <= ST_DRIVE;
            out_rev_q <= want_rev;
          end
          else
            dz_cnt_q <= dz_cnt_q + 40'h1;
        end
      endcase
    end
  end

  // run and jog state; jog keeps its own ramp until it has stopped
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      run_q        <= 1'b0;
      jog_q        <= 1'b0;
      start_mode_q <= `MODE_DIRECT;
      stop_mode_q  <= `STOP_DECEL;
    end
    else
    begin
      run_q        <= run_d;
      jog_q        <= jog_d || (jog_q && !term.run && out_freq_q != `ZERO_F);
      start_mode_q <= jog_d ? `MODE_DIRECT : cfg_q[`R_START_MODE][1:0];
      stop_mode_q  <= (jog_d || jog_q) ? `STOP_DECEL : cfg_q[`R_STOP_MODE][0];
    end
  end

  // hour counters: 0 counts power-on time, 1 counts running time
  for (genvar k = 0; k < 2; k++)
  begin : g_hours
    always_ff @(posedge clock)
    begin
      if (sys_rst)
      begin
        hr_pre_q[k] <= 40'h0;
        hr_cnt_q[k] <= 16'h0000;
      end
      else if (k == 0 || run_q)
      begin
        if (hr_pre_q[k] == 40'(CYC_PER_HOUR - 64'h1))
        begin
          hr_pre_q[k] <= 40'h0;
          if (hr_cnt_q[k] != `HOUR_MAX)
            hr_cnt_q[k] <= hr_cnt_q[k] + 16'h0001;
        end
        else
          hr_pre_q[k] <= hr_pre_q[k] + 40'h1;
      end
    end
  end

  // whole-hour compare; a level while count is at or above threshold
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      pon_reached_q <= 1'b0;
      run_reached_q <= 1'b0;
    end
    else
    begin
      pon_reached_q <= hr_cnt_q[0] >= cfg_q[`R_PON_THR];
      run_reached_q <= hr_cnt_q[1] >= cfg_q[`R_RUN_THR];
    end
  end

  assign stat = '{pad: 10'h000, dead: state_q == ST_DEAD, jog: jog_q, run: run_q,
                  rev: out_rev_q, pon: pon_reached_q, runr: run_reached_q};

  // read data stand for one cycle only, zero otherwise
  always_ff @(posedge clock)
  begin
    if (sys_rst || !bus.rd)
      rd_data_q <= 16'h0000;
    else if (bus.addr < 5'(`NCFG))
      rd_data_q <= cfg_q[bus.addr];
    else if (bus.addr == `R_PON_CNT)
      rd_data_q <= hr_cnt_q[0];
    else if (bus.addr == `R_RUN_CNT)
      rd_data_q <= hr_cnt_q[1];
    else if (bus.addr == `R_STATUS)
      rd_data_q <= stat;
    else
      rd_data_q <= out_freq_q;
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  property p_jog_tgt;
    jog_d && run_d && state_q == ST_DRIVE |-> tgt_raw == cfg_q[`R_JOG_F];
  endproperty
  a_jog_tgt: assert property (p_jog_tgt) else $error("jog target wrong");

  property p_jog_mode;
    $rose(jog_q) |-> start_mode_q == `MODE_DIRECT && stop_mode_q == `STOP_DECEL;
  endproperty
  a_jog_mode: assert property (p_jog_mode) else $error("jog modes wrong");

  property p_sel_grp;
    term.sel_act |-> grp == term.digital_input_terminal;
  endproperty
  a_sel_grp: assert property (p_sel_grp) else $error("terminal group ignored");

  property p_skip_edge;
    tgt_in |-> tgt_sk == t_lo || tgt_sk == t_hi;
  endproperty
  a_skip_edge: assert property (p_skip_edge) else $error("target left in band");

  property p_skip_off;
    cfg_q[`R_SKIP1] == `ZERO_F && cfg_q[`R_SKIP2] == `ZERO_F |-> tgt_sk == tgt_dr;
  endproperty
  a_skip_off: assert property (p_skip_off) else $error("skip not disabled");

  sequence s_in_band;
    cfg_q[`R_SKIP_RAMP][0] && nf_in && !free;
  endsequence
  property p_skip_ramp;
    s_in_band |=> out_freq_q == $past(nf_lo) || out_freq_q == $past(nf_hi);
  endproperty
  a_skip_ramp: assert property (p_skip_ramp) else $error("ramp did not jump");

  property p_up_sw;
    term.motor_one && !term.sel_act && !jog_q && up && out_freq_q < cfg_q[`R_UP_SW]
      |-> act_time == cfg_q[`R_UP1];
  endproperty
  a_up_sw: assert property (p_up_sw) else $error("up time 1 not used");

  property p_dn_sw;
    term.motor_one && !term.sel_act && !jog_q && down && out_freq_q <= cfg_q[`R_DN_SW]
      |-> act_time == cfg_q[`R_DN2];
  endproperty
  a_dn_sw: assert property (p_dn_sw) else $error("down time 2 not used");

  property p_rev_inh;
    $rose(out_rev_q) |-> !$past(cfg_q[`R_REV_INH][0]);
  endproperty
  a_rev_inh: assert property (p_rev_inh) else $error("reverse while inhibited");

  sequence s_turn;
    state_q == ST_DRIVE ##1 state_q == ST_DEAD;
  endsequence
  property p_dead;
    s_turn |-> out_freq_q == `ZERO_F ##1 out_freq_q == `ZERO_F || state_q == ST_DRIVE;
  endproperty
  a_dead: assert property (p_dead) else $error("output moved in dead zone");

  property p_flip;
    $changed(out_rev_q) |-> $past(out_freq_q) == `ZERO_F;
  endproperty
  a_flip: assert property (p_flip) else $error("direction flipped while turning");

  property p_low_stop;
    stop_low |=> !run_q && out_freq_q <= $past(out_freq_q);
  endproperty
  a_low_stop: assert property (p_low_stop) else $error("low setpoint did not stop");

  property p_droop;
    tgt_dr <= tgt_raw && tgt_raw - tgt_dr <= `DROOP_MAX;
  endproperty
  a_droop: assert property (p_droop) else $error("droop out of range");

  property p_jog_prio;
    term.jog && term.run && run_q && cfg_q[`R_JOG_PRIO][0] && !stop_time |=> jog_q;
  endproperty
  a_jog_prio: assert property (p_jog_prio) else $error("jog priority ignored");

  property p_pon;
    hr_cnt_q[0] >= cfg_q[`R_PON_THR] |=> pon_reached_q;
  endproperty
  a_pon: assert property (p_pon) else $error("power-on flag late");

  property p_run_hr;
    hr_cnt_q[1] >= cfg_q[`R_RUN_THR] |=> run_reached_q;
  endproperty
  a_run_hr: assert property (p_run_hr) else $error("run-time flag late");

  property p_run_stop;
    run_reached_q && cfg_q[`R_RUN_ACT] == `ACT_STOP |=> !run_q;
  endproperty
  a_run_stop: assert property (p_run_stop) else $error("run time did not stop");

  property p_hold;
    pon_reached_q && $stable(cfg_q[`R_PON_THR]) |=> pon_reached_q;
  endproperty
  a_hold: assert property (p_hold) else $error("reached flag dropped");
endmodule

// ===== rtl/dfr_map.svh
`ifndef DFR_MAP_SVH
`define DFR_MAP_SVH
// How it works
// - jogging uses jog frequency and jog ramp times; jog frequency defaults 6.00 Hz
// - jogging always starts directly and decelerates to stop, whatever modes say
// - four ramp up/down pairs, 0 to 6500.0 s, picked by input terminals
// - requested frequency inside a skip band runs at the nearest band edge
// - both skip frequencies at zero switches skipping off
// - skip during ramps on: running frequency jumps across the band
// - ramping up uses time 1 below up switch frequency, time 2 above
// - ramping down uses time 1 above down switch frequency, time 2 below
// - frequency switchover only with motor 1 and no terminal ramp selection
// - reverse inhibit 0 allows reverse rotation, 1 forbids it
// - direction change holds output at 0 Hz for dead-zone time, up to 3000.0 s
// - below lower limit: 0 runs at limit, 1 stops, 2 runs at zero
// - droop lowers output as load rises, by at most the setting, 10.00 Hz
// - terminal jog priority on: terminal jog while running switches to jogging
// - power-on hours reaching threshold (0 to 65000 h) raise the power-on flag
// - run hours reaching threshold (0 to 65000 h) raise the run-time flag
// - run time reached: action 0 keeps running, 1 stops
// - action 1 stops the drive once the run time is reached

// widths
`define DW 16
`define AW 5
// register indices, one 16-bit register each
`define R_JOG_F      5'h00
`define R_JOG_UP     5'h01
`define R_JOG_DN     5'h02
`define R_UP1        5'h03
`define R_DN2        5'h06
`define R_GRP_LAST   5'h0a
`define R_SKIP1      5'h0b
`define R_SKIP2      5'h0c
`define R_SKIP_AMP   5'h0d
`define R_SKIP_RAMP  5'h0e
`define R_UP_SW      5'h0f
`define R_DN_SW      5'h10
`define R_REV_INH    5'h11
`define R_DEAD_T     5'h12
`define R_LOW_MODE   5'h13
`define R_DROOP      5'h14
`define R_JOG_PRIO   5'h15
`define R_PON_THR    5'h16
`define R_RUN_THR    5'h17
`define R_RUN_ACT    5'h18
`define R_LOW_LIM    5'h19
`define R_START_MODE 5'h1a
`define R_STOP_MODE  5'h1b
`define NCFG         28
`define R_PON_CNT    5'h1c
`define R_RUN_CNT    5'h1d
`define R_STATUS     5'h1e
`define R_OUT_F      5'h1f
// reset values and codes
`define JOG_F_RST    16'h0258
`define TIME_RST     16'h00c8
`define LOW_LIMIT    16'h0000
`define LOW_STOP     16'h0001
`define ACT_STOP     16'h0001
`define MODE_DIRECT  2'h0
`define STOP_DECEL   1'b0
`define DROOP_MAX    16'h03e8
`define FREQ_MAX     16'hffff
`define HOUR_MAX     16'hffff
`define ZERO_F       16'h0000
// timing
`define RAMP_FULL    40'h0000001388
`define CLK_NS       50
`define TENTH_NS     100000000
`define TENTH_PER_H  36000
`define LOAD_SHIFT   8
`endif

// ===== rtl/dfr_pkg.sv
`include "dfr_map.svh"
package dfr_pkg;
  typedef struct packed {
    logic                run;
    logic                rev;
    logic                jog;
    logic                sel_act;
    logic [1:0]          digital_input_terminal;
    logic                motor_one;
  } dfr_term_t;
  typedef struct packed {
    logic [`AW-1:0]      addr;
    logic [`DW-1:0]      wdata;
    logic                wr;
    logic                rd;
  } dfr_bus_t;
  typedef struct packed {
    logic [9:0]          pad;
    logic                dead;
    logic                jog;
    logic                run;
    logic                rev;
    logic                pon;
    logic                runr;
  } dfr_status_t;
  typedef enum logic {ST_DRIVE, ST_DEAD} dfr_state_t;
endpackage

// ===== rtl/dfr_skip.sv
`timescale 1ns/1ps
`include "dfr_map.svh"
module dfr_skip
(
  input  wire logic [15:0] freq,
  input  wire logic [15:0] skip_one,
  input  wire logic [15:0] skip_two,
  input  wire logic [15:0] amp,
  output logic             in_band,
  output logic [15:0]      band_lo,
  output logic [15:0]      band_hi,
  output logic [15:0]      nearest
);
  logic [15:0] ctr [2];
  logic [15:0] lo  [2];
  logic [15:0] hi  [2];
  logic [1:0]  hit;
  logic [15:0] mid;

  assign ctr[0] = skip_one;
  assign ctr[1] = skip_two;

  // a zero centre marks an unused band, so both zero turns skipping off
  for (genvar k = 0; k < 2; k++)
  begin : g_band
    logic [16:0] top;
    assign top    = 17'(ctr[k]) + 17'(amp);
    assign lo[k]  = (ctr[k] > amp) ? ctr[k] - amp : `ZERO_F;
    assign hi[k]  = top[16] ? `FREQ_MAX : top[15:0];
    assign hit[k] = (ctr[k] != `ZERO_F) && (freq > lo[k]) && (freq < hi[k]);
  end

  // band one wins where the two overlap; edges themselves are legal
  always_comb
  begin
    in_band = |hit;
    band_lo = hit[0] ? lo[0] : lo[1];
    band_hi = hit[0] ? hi[0] : hi[1];
    mid     = hit[0] ? ctr[0] : ctr[1];
    nearest = freq;
    if (in_band)
      nearest = (freq < mid) ? band_lo : band_hi;
  end
endmodule

// ===== tb/dfr_aux_tb.sv
`timescale 1ns/1ps
`include "dfr_map.svh"
module dfr_aux_tb;
  import dfr_pkg::*;
  localparam int TENTH = 2;
  logic        clock;
  logic        sys_rst;
  logic        clr;
  logic        watch;
  logic        band_hit;
  dfr_bus_t    bus;
  dfr_term_t   term;
  logic [15:0] set_freq;
  logic [15:0] rd_data_q;
  logic [15:0] out_freq_q;
  logic [15:0] zero_max;
  logic [15:0] rdv;
  logic [7:0]  load_level;
  logic [7:0]  load_req;
  logic        out_rev_q;
  logic        run_q;
  logic        jog_q;
  logic [1:0]  start_mode_q;
  logic        stop_mode_q;
  logic        pon_reached_q;
  logic        run_reached_q;
  int          fail_count;
  int          checked;

  dfr_aux #(.CYC_PER_TENTH(TENTH), .CYC_PER_HOUR(20)) DUT (
    .clock(clock), .sys_rst(sys_rst), .bus(bus), .rd_data_q(rd_data_q), .term(term),
    .set_freq(set_freq), .load_level(load_level), .out_freq_q(out_freq_q),
    .out_rev_q(out_rev_q), .run_q(run_q), .jog_q(jog_q), .start_mode_q(start_mode_q),
    .stop_mode_q(stop_mode_q), .pon_reached_q(pon_reached_q),
    .run_reached_q(run_reached_q));

  dfr_motor motor (
    .clock(clock), .out_freq(out_freq_q), .run(run_q), .load_req(load_req), .clr(clr),
    .load_level(load_level), .zero_max(zero_max));

  always #25 clock = ~clock;

  // latch any visit strictly inside the 250..350 band while watched
  always @(posedge clock)
  begin
    if (sys_rst)
      band_hit <= 1'b0;
    else if (watch && out_freq_q > 16'h00fa && out_freq_q < 16'h015e)
      band_hit <= 1'b1;
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // every bus and wait task starts and ends just after a rising edge; look ends on a falling edge
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge clock);
    bus.wr <= 1'b0;
    @(posedge clock);
  endtask

  // read data stands only in the cycle after the strobe, sampled mid-cycle
  task automatic rd(input logic [4:0] a);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clock);
    bus.rd <= 1'b0;
    @(negedge clock);
    rdv = rd_data_q;
    @(posedge clock);
  endtask

  task automatic look(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask

  task automatic wait_out(input logic [15:0] exp, input int n);
    int i;
    i = 0;
    do
    begin
      @(negedge clock);
      i++;
    end
    while (out_freq_q !== exp && i < n);
    check("out_freq_q", out_freq_q, exp);
    @(posedge clock);
  endtask

  task automatic wait_flag(input bit sel);
    int i;
    i = 0;
    do
    begin
      @(negedge clock);
      i++;
    end
    while ((sel ? run_reached_q : pon_reached_q) !== 1'b1 && i < 200);
    check("hours flag", 16'(sel ? run_reached_q : pon_reached_q), 16'h0001);
    @(posedge clock);
  endtask

  task automatic t_regs();
    rd(`R_JOG_F);
    check("jog freq reset", rdv, `JOG_F_RST);
    rd(`R_JOG_UP);
    check("jog up reset", rdv, `TIME_RST);
    // zero ramp times step one unit per cycle, keeping the run short
    for (logic [4:0] a = `R_JOG_UP; a <= `R_GRP_LAST; a++)
      wr(a, 16'h0000);
    wr(`R_JOG_F, 16'h0064);
    rd(`R_JOG_F);
    check("jog freq write", rdv, 16'h0064);
    $display("test regs done");
  endtask

  task automatic t_jog();
    wr(`R_START_MODE, 16'h0001);
    wr(`R_STOP_MODE, 16'h0001);
    term.jog <= 1'b1;
    look(2);
    check("jog_q", 16'(jog_q), 16'h0001);
    check("start_mode_q", 16'(start_mode_q), 16'h0000);
    check("stop_mode_q", 16'(stop_mode_q), 16'h0000);
    @(posedge clock);
    wait_out(16'h0064, 300);
    // the output frequency index is read-only: the write must not land
    wr(`R_OUT_F, 16'h1234);
    rd(`R_OUT_F);
    check("out freq read", rdv, 16'h0064);
    term.jog <= 1'b0;
    look(2);
    check("jog decel", 16'(out_freq_q > 16'h0050), 16'h0001);
    @(posedge clock);
    wait_out(16'h0000, 300);
    wr(`R_START_MODE, 16'h0000);
    wr(`R_STOP_MODE, 16'h0000);
    $display("test jog done");
  endtask

  task automatic t_skip();
    // switchover points change only the group; all group times are zero here
    wr(`R_UP_SW, 16'h00c8);
    wr(`R_DN_SW, 16'h012c);
    wr(`R_SKIP1, 16'h012c);
    wr(`R_SKIP_AMP, 16'h0032);
    term.run <= 1'b1;
    set_freq <= 16'h0140;
    wait_out(16'h015e, 600);
    set_freq <= 16'h0118;
    wait_out(16'h00fa, 600);
    wr(`R_SKIP_RAMP, 16'h0001);
    watch <= 1'b1;
    set_freq <= 16'h01f4;
    wait_out(16'h01f4, 600);
    watch <= 1'b0;
    check("band crossed", 16'(band_hit), 16'h0000);
    wr(`R_SKIP1, 16'h0000);
    set_freq <= 16'h0140;
    wait_out(16'h0140, 600);
    set_freq <= 16'h0064;
    wait_out(16'h0064, 600);
    $display("test skip done");
  endtask

  task automatic t_rev();
    wr(`R_REV_INH, 16'h0001);
    term.rev <= 1'b1;
    look(20);
    check("reverse refused", 16'(out_rev_q), 16'h0000);
    check("speed kept", out_freq_q, 16'h0064);
    @(posedge clock);
    clr <= 1'b1;
    wr(`R_DEAD_T, 16'h0005);
    clr <= 1'b0;
    wr(`R_REV_INH, 16'h0000);
    look(30);
    @(posedge clock);
    wait_out(16'h0064, 600);
    look(0);
    check("reversed", 16'(out_rev_q), 16'h0001);
    check("dead zone", 16'(zero_max >= 16'(5 * TENTH)), 16'h0001);
    @(posedge clock);
    term.rev <= 1'b0;
    term.run <= 1'b0;
    wait_out(16'h0000, 600);
    $display("test reverse done");
  endtask

  task automatic t_lim();
    logic [15:0] exp [3];
    exp = '{16'h00c8, 16'h0000, 16'h0000};
    wr(`R_LOW_LIM, 16'h00c8);
    term.run <= 1'b1;
    set_freq <= 16'h0064;
    for (int m = 0; m < 3; m++)
    begin
      wr(`R_LOW_MODE, 16'(m));
      wait_out(exp[m], 600);
      look(0);
      check("low run", 16'(run_q), 16'(m != 1));
      @(posedge clock);
    end
    wr(`R_LOW_MODE, 16'h0000);
    wr(`R_LOW_LIM, 16'h0000);
    $display("test lower limit done");
  endtask

  task automatic t_droop();
    wr(`R_DROOP, 16'h0064);
    load_req <= 8'h80;
    set_freq <= 16'h0190;
    wait_out(16'h015e, 800);
    wr(`R_UP1 + 5'h04, 16'h1388);
    // terminals pick group 3, whose slower up time halves the climb rate
    term.sel_act <= 1'b1;
    term.digital_input_terminal <= 2'h2;
    load_req <= 8'h00;
    look(20);
    check("terminal group rate", out_freq_q, 16'h0168);
    @(posedge clock);
    wait_out(16'h0190, 300);
    wr(`R_DROOP, 16'h0000);
    term.sel_act <= 1'b0;
    $display("test droop done");
  endtask

  task automatic t_prio();
    term.jog <= 1'b1;
    look(3);
    check("jog refused", 16'(jog_q), 16'h0000);
    @(posedge clock);
    wr(`R_JOG_PRIO, 16'h0001);
    look(3);
    check("jog priority", 16'(jog_q), 16'h0001);
    @(posedge clock);
    term.jog <= 1'b0;
    term.run <= 1'b0;
    wait_out(16'h0000, 800);
    $display("test jog priority done");
  endtask

  task automatic t_hours();
    wr(`R_PON_THR, 16'hffff);
    look(2);
    check("pon below", 16'(pon_reached_q), 16'h0000);
    @(posedge clock);
    rd(`R_PON_CNT);
    wr(`R_PON_THR, rdv + 16'h0002);
    wait_flag(1'b0);
    term.run <= 1'b1;
    set_freq <= 16'h0064;
    rd(`R_RUN_CNT);
    wr(`R_RUN_THR, rdv + 16'h0001);
    wait_flag(1'b1);
    look(2);
    check("keeps running", 16'(run_q), 16'h0001);
    @(posedge clock);
    wr(`R_STOP_MODE, 16'h0001);
    wr(`R_RUN_ACT, 16'h0001);
    look(3);
    check("stops at run time", 16'(run_q), 16'h0000);
    check("free stop", out_freq_q, 16'h0000);
    $display("test hours done");
  endtask

  initial
  begin
    clock = 1'b0;
    sys_rst = 1'b1;
    clr = 1'b1;
    watch = 1'b0;
    bus = '0;
    term = '0;
    term.motor_one = 1'b1;
    set_freq = 16'h0000;
    load_req = 8'h00;
    fail_count = 0;
    checked = 0;
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    clr <= 1'b0;
    @(posedge clock);
    t_regs();
    t_jog();
    t_skip();
    t_rev();
    t_lim();
    t_droop();
    t_prio();
    t_hours();
    conclude();
  end

  // the whole sequence takes about 3000 cycles; over six times that means a hang
  initial
  begin
    repeat (20000) @(posedge clock);
    fail_count++;
    $display("BAD watchdog expected finish seen hang");
    conclude();
  end
endmodule

// ===== tb/dfr_motor.sv
`timescale 1ns/1ps
module dfr_motor
(
  input  wire logic        clock,
  input  wire logic [15:0] out_freq,
  input  wire logic        run,
  input  wire logic [7:0]  load_req,
  input  wire logic        clr,
  output logic [7:0]       load_level,
  output logic [15:0]      zero_max
);
  logic [15:0] zero_len;
  // the shaft only loads the drive while it is driven
  assign load_level = run ? load_req : 8'h00;
  // longest run with zero output while commanded, i.e. the reversal pause
  always_ff @(posedge clock)
  begin
    if (clr)
    begin
      zero_len <= 16'h0000;
      zero_max <= 16'h0000;
    end
    else
    begin
      zero_len <= (run && out_freq == 16'h0000) ? zero_len + 16'h0001 : 16'h0000;
      if (zero_len > zero_max)
        zero_max <= zero_len;
    end
  end
endmodule
